// *** hw/alu_ops_pkg.sv ***
/*
  Shared constants and types for the subtract, rotate, swap, exclusive-OR
  and power-down execution unit.
  Assumes a single core clock and an instruction decoder that presents one
  operation at a time.
*/
`default_nettype none
package alu_ops_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int NIB_W  = 4;

  localparam logic [DATA_W-1:0] WORK_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] WATCHDOG_ZERO = 8'h00;
  localparam int WDOG_W                       = 8;
  localparam int PRESC_W                      = 8;

  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Status flag reset levels.
  localparam logic CARRY_RESET = 1'b0;
  localparam logic DIGIT_RESET = 1'b0;
  localparam logic ZERO_RESET  = 1'b0;
  localparam logic TIMEOUT_RESET   = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;

  // Operation selector driven by the decoder.
  typedef enum logic [2:0] {
    OP_NONE             = 3'h0,
    OP_SLEEP            = 3'h1,
    SUB_FROM_LITERAL_OP = 3'h2,
    ROTATE_RIGHT_CARRY_OP = 3'h3,
    SUB_FROM_FILE_OP    = 3'h4,
    NIBBLE_SWAP_OP      = 3'h5,
    XOR_LITERAL_OP      = 3'h6,
    XOR_FILE_OP         = 3'h7
  } op_e;

  typedef enum logic [0:0] {
    RUN_ST   = 1'b0,
    SLEEP_ST = 1'b1
  } run_e;

endpackage
`default_nettype wire

// *** hw/sub_unit.sv ***
/*
  Two's complement subtractor: minuend minus subtrahend with carry and
  digit carry meaning "no borrow".
  Assumes purely combinational use by the execution unit.
*/
`timescale 1ns/1ps
`default_nettype none
module sub_unit
  import alu_ops_pkg::*;
(
  // Operands.
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  // Results.
  output logic      [DATA_W-1:0] diff,
  output logic                   no_borrow,
  output logic                   nib_no_borrow
);

  logic [DATA_W:0] full;
  logic [NIB_W:0]  low;

  always_comb begin
    // Adding the complement plus one gives carry out equal to not-borrow.
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DATA_W{1'b0}}, 1'b1};
    low  = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~subtrahend[NIB_W-1:0]}
         + {{NIB_W{1'b0}}, 1'b1};
    diff          = full[DATA_W-1:0];
    no_borrow     = full[DATA_W];
    nib_no_borrow = low[NIB_W];
  end

endmodule // sub_unit
`default_nettype wire

// *** hw/logic_unit.sv ***
/*
  Bitwise and shift unit: right rotate through carry, nibble swap and
  exclusive-OR.
  Assumes purely combinational use by the execution unit.
*/
`timescale 1ns/1ps
`default_nettype none
module logic_unit
  import alu_ops_pkg::*;
(
  // Operands.
  input  wire logic [DATA_W-1:0] file_val,
  input  wire logic [DATA_W-1:0] other_val,
  input  wire logic              carry_in,
  // Results.
  output logic      [DATA_W-1:0] rot_val,
  output logic                   rot_carry,
  output logic      [DATA_W-1:0] swap_val,
  output logic      [DATA_W-1:0] xor_val
);

  always_comb begin
    rot_val   = {carry_in, file_val[DATA_W-1:1]};
    rot_carry = file_val[0];
    swap_val  = {file_val[NIB_W-1:0], file_val[DATA_W-1:NIB_W]};
    xor_val   = file_val ^ other_val;
  end

endmodule // logic_unit
`default_nettype wire

// *** hw/alu_exec.sv ***
/*
  Execution unit for power-down, subtraction, right rotate, nibble swap and
  exclusive-OR operations of an 8-bit core.
  Assumes the decoder gives one operation per valid cycle, the file register
  value is already read, and the file write port accepts the write pulse.
*/
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module alu_exec
  import alu_ops_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst,
  // Decoded operation.
  input  wire logic              op_valid,
  input  wire op_e               op,
  input  wire logic [DATA_W-1:0] literal,
  input  wire logic [ADDR_W-1:0] file_addr,
  input  wire logic              dest_sel,
  // File register read data for file_addr.
  input  wire logic [DATA_W-1:0] file_rdata,
  // Wake event from outside, leaves the sleep state.
  input  wire logic              wake,
  // File register write port.
  output logic                   file_we,
  output logic      [ADDR_W-1:0] file_waddr,
  output logic      [DATA_W-1:0] file_wdata,
  // Working register and status.
  output logic      [DATA_W-1:0] work_reg,
  output logic                   carry_flag,
  output logic                   digit_carry_flag,
  output logic                   zero_flag,
  output logic                   time_out_flag,
  output logic                   power_down_flag,
  // Watchdog and oscillator control.
  output logic      [WDOG_W-1:0] watchdog_counter,
  output logic                   watchdog_clear,
  output logic                   prescaler_clear,
  output logic                   osc_stop,
  output logic                   sleeping
);

  typedef struct packed {
    logic [DATA_W-1:0] work;
    logic              c;
    logic              dcarry;
    logic              z;
    logic              tout;
    logic              pdown;
    logic [WDOG_W-1:0] wdog;
    logic              wd_clr;
    logic              ps_clr;
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    run_e              run;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [DATA_W-1:0] sub_a;
  logic [DATA_W-1:0] diff;
  logic              nb;
  logic              nnb;
  logic [DATA_W-1:0] rot_val;
  logic              rot_c;
  logic [DATA_W-1:0] swap_val;
  logic [DATA_W-1:0] bit_src;
  logic [DATA_W-1:0] xor_val;

  // Result sources on the shared result path.
  typedef enum logic [1:0] {
    RES_DIFF = 2'b00,
    RES_ROT  = 2'b01,
    RES_SWAP = 2'b10,
    RES_XOR  = 2'b11
  } res_e;

  // What one operation may change; every part not marked here holds.
  typedef struct packed {
    logic power_down;
    logic has_dest;
    logic to_work;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    res_e src;
  } effect_s;

  effect_s           eff;
  logic [DATA_W-1:0] res;

  // Store a result to the working or file register as dest selects.
  function automatic state_s route(
    input logic              d,
    input logic [DATA_W-1:0] v,
    input state_s            s
  );
    state_s t;
    t = s;
    if (d == DEST_FILE) begin
      t.we    = 1'b1;
      t.wdata = v;
    end else begin
      t.work  = v;
    end
    route = t;
  endfunction

  // The flag table, one full row per operation: keeping every field in each
  // row makes a missing or stray flag update visible at a glance.
  function automatic effect_s op_effect(input op_e o);
    effect_s e;
    case (o)
      OP_SLEEP: begin
        e.power_down = 1'b1;
        e.has_dest   = 1'b0;
        e.to_work    = 1'b0;
        e.upd_c      = 1'b0;
        e.upd_dc     = 1'b0;
        e.upd_z      = 1'b0;
        e.src        = RES_DIFF;
      end
      SUB_FROM_LITERAL_OP: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b0;
        e.to_work    = 1'b1;
        e.upd_c      = 1'b1;
        e.upd_dc     = 1'b1;
        e.upd_z      = 1'b1;
        e.src        = RES_DIFF;
      end
      SUB_FROM_FILE_OP: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b1;
        e.to_work    = 1'b0;
        e.upd_c      = 1'b1;
        e.upd_dc     = 1'b1;
        e.upd_z      = 1'b1;
        e.src        = RES_DIFF;
      end
      ROTATE_RIGHT_CARRY_OP: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b1;
        e.to_work    = 1'b0;
        e.upd_c      = 1'b1;
        e.upd_dc     = 1'b0;
        e.upd_z      = 1'b0;
        e.src        = RES_ROT;
      end
      NIBBLE_SWAP_OP: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b1;
        e.to_work    = 1'b0;
        e.upd_c      = 1'b0;
        e.upd_dc     = 1'b0;
        e.upd_z      = 1'b0;
        e.src        = RES_SWAP;
      end
      XOR_LITERAL_OP: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b0;
        e.to_work    = 1'b1;
        e.upd_c      = 1'b0;
        e.upd_dc     = 1'b0;
        e.upd_z      = 1'b1;
        e.src        = RES_XOR;
      end
      XOR_FILE_OP: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b1;
        e.to_work    = 1'b0;
        e.upd_c      = 1'b0;
        e.upd_dc     = 1'b0;
        e.upd_z      = 1'b1;
        e.src        = RES_XOR;
      end
      default: begin
        e.power_down = 1'b0;
        e.has_dest   = 1'b0;
        e.to_work    = 1'b0;
        e.upd_c      = 1'b0;
        e.upd_dc     = 1'b0;
        e.upd_z      = 1'b0;
        e.src        = RES_DIFF;
      end
    endcase
    op_effect = e;
  endfunction

  // Picks the value that the operation stores.
  function automatic logic [DATA_W-1:0] pick_result(
    input res_e              src,
    input logic [DATA_W-1:0] d,
    input logic [DATA_W-1:0] r,
    input logic [DATA_W-1:0] s,
    input logic [DATA_W-1:0] x
  );
    case (src)
      RES_DIFF: pick_result = d;
      RES_ROT:  pick_result = r;
      RES_SWAP: pick_result = s;
      RES_XOR:  pick_result = x;
      default:  pick_result = d;
    endcase
  endfunction

  // Rotate takes its carry from the bit shifted out; the subtracts take it
  // from the borrow out of the full-width difference.
  function automatic logic pick_carry(input res_e src, input logic rc,
                                      input logic sc);
    if (src == RES_ROT) begin
      pick_carry = rc;
    end else begin
      pick_carry = sc;
    end
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == {DATA_W{1'b0}});
  endfunction

  always_comb begin
    sub_a     = (op == SUB_FROM_LITERAL_OP) ? literal : file_rdata;
    bit_src   = (op == XOR_LITERAL_OP) ? literal : file_rdata;
  end

  sub_unit u_sub (
    .minuend       (sub_a),
    .subtrahend    (st_q.work),
    .diff          (diff),
    .no_borrow     (nb),
    .nib_no_borrow (nnb)
  );

  logic_unit u_logic (
    .file_val  (bit_src),
    .other_val (st_q.work),
    .carry_in  (st_q.c),
    .rot_val   (rot_val),
    .rot_carry (rot_c),
    .swap_val  (swap_val),
    .xor_val   (xor_val)
  );

  always_comb begin
    eff         = op_effect(op);
    res         = pick_result(eff.src, diff, rot_val, swap_val, xor_val);
    st_d        = st_q;
    st_d.we     = 1'b0;
    st_d.wd_clr = 1'b0;
    st_d.ps_clr = 1'b0;
    st_d.waddr  = file_addr;
    case (st_q.run)
      SLEEP_ST: begin
        // Instructions are not executed while the oscillator is stopped.
        if (wake) begin
          st_d.run = RUN_ST;
        end
      end
      RUN_ST: begin
        if (op_valid && eff.power_down) begin
          st_d.wdog   = WATCHDOG_ZERO;
          st_d.wd_clr = 1'b1;
          st_d.ps_clr = 1'b1;
          st_d.tout   = 1'b1;
          st_d.pdown  = 1'b0;
          st_d.run    = SLEEP_ST;
        end
        // Literal operations have no destination bit and always hit work.
        if (op_valid && eff.has_dest) begin
          st_d = route(dest_sel, res, st_d);
        end
        if (op_valid && eff.to_work) begin
          st_d.work = res;
        end
        if (op_valid && eff.upd_c) begin
          st_d.c = pick_carry(eff.src, rot_c, nb);
        end
        if (op_valid && eff.upd_dc) begin
          st_d.dcarry = nnb;
        end
        if (op_valid && eff.upd_z) begin
          st_d.z = is_zero(res);
        end
      end
      default: begin
        st_d.run = RUN_ST;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q.work   <= WORK_RESET;
      st_q.c      <= CARRY_RESET;
      st_q.dcarry <= DIGIT_RESET;
      st_q.z      <= ZERO_RESET;
      st_q.tout   <= TIMEOUT_RESET;
      st_q.pdown  <= POWERDOWN_RESET;
      st_q.wdog   <= WATCHDOG_ZERO;
      st_q.wd_clr <= 1'b0;
      st_q.ps_clr <= 1'b0;
      st_q.we     <= 1'b0;
      st_q.waddr  <= {ADDR_W{1'b0}};
      st_q.wdata  <= WORK_RESET;
      st_q.run    <= RUN_ST;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    file_we          = st_q.we;
    file_waddr       = st_q.waddr;
    file_wdata       = st_q.wdata;
    work_reg         = st_q.work;
    carry_flag       = st_q.c;
    digit_carry_flag = st_q.dcarry;
    zero_flag        = st_q.z;
    time_out_flag    = st_q.tout;
    power_down_flag  = st_q.pdown;
    watchdog_counter = st_q.wdog;
    watchdog_clear   = st_q.wd_clr;
    prescaler_clear  = st_q.ps_clr;
    osc_stop         = (st_q.run == SLEEP_ST);
    sleeping         = (st_q.run == SLEEP_ST);
  end

endmodule // alu_exec
`default_nettype wire

// *** sim/alu_exec_props.sv ***
/*
  Port-level assertions for the execution unit alu_exec.
  Assumes it is bound to alu_exec: one clock, rst synchronous, active high.
*/
`timescale 1ns/1ps
`default_nettype none
module alu_exec_props
  import alu_ops_pkg::*;
(
  // Clock, reset and decoded operation.
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              op_valid,
  input wire op_e               op,
  input wire logic [DATA_W-1:0] literal,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic              dest_sel,
  input wire logic [DATA_W-1:0] file_rdata,
  // Results and status.
  input wire logic              file_we,
  input wire logic [ADDR_W-1:0] file_waddr,
  input wire logic [DATA_W-1:0] work_reg,
  input wire logic              carry_flag,
  input wire logic              digit_carry_flag,
  input wire logic              zero_flag,
  input wire logic              time_out_flag,
  input wire logic              power_down_flag,
  input wire logic [WDOG_W-1:0] watchdog_counter,
  input wire logic              watchdog_clear,
  input wire logic              prescaler_clear,
  input wire logic              osc_stop,
  input wire logic              sleeping
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // An operation counts only when offered outside the sleep state.
  sequence take(op_e o);
    op_valid && !sleeping && op == o;
  endsequence

  wdog_clear_a: assert property (
    take(OP_SLEEP) |=> watchdog_clear && prescaler_clear &&
      watchdog_counter == WATCHDOG_ZERO) else $error("watchdog kept");
  sleep_flags_a: assert property (
    take(OP_SLEEP) |=> !power_down_flag && time_out_flag &&
      $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("sleep flags wrong");
  sleep_state_a: assert property (
    take(OP_SLEEP) |=> sleeping && osc_stop) else $error("no sleep");
  sub_lit_a: assert property (
    take(SUB_FROM_LITERAL_OP) |=> work_reg == $past(literal) -
      $past(work_reg)) else $error("literal difference wrong");
  rot_carry_a: assert property (
    take(ROTATE_RIGHT_CARRY_OP) |=> carry_flag == $past(file_rdata[0]) &&
      $stable({digit_carry_flag, zero_flag})) else $error("rotate wrong");
  dest_file_a: assert property (
    op_valid && !sleeping && dest_sel && op inside {ROTATE_RIGHT_CARRY_OP,
      SUB_FROM_FILE_OP, NIBBLE_SWAP_OP, XOR_FILE_OP} |=> file_we &&
      file_waddr == $past(file_addr)) else $error("file write missing");
  sub_carry_a: assert property (
    take(SUB_FROM_FILE_OP) |=> carry_flag ==
      ($past(file_rdata) >= $past(work_reg))) else $error("borrow wrong");
  swap_flags_a: assert property (
    take(NIBBLE_SWAP_OP) |=> $stable({carry_flag, digit_carry_flag,
      zero_flag})) else $error("swap changed flags");
  xor_zero_a: assert property (
    take(XOR_LITERAL_OP) |=> work_reg == ($past(work_reg) ^
      $past(literal)) && zero_flag == (work_reg == 8'h00) &&
      $stable(carry_flag)) else $error("xor zero wrong");
  sleep_ignore_a: assert property (
    op_valid && sleeping |=> $stable(work_reg) && !file_we &&
      $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("op run while asleep");
  xor_file_a: assert property (
    take(XOR_FILE_OP) |=> zero_flag ==
      (($past(work_reg) ^ $past(file_rdata)) == 8'h00))
    else $error("file xor zero wrong");
endmodule // alu_exec_props

bind alu_exec alu_exec_props u_props (
  .clock            (clock),
  .rst              (rst),
  .op_valid         (op_valid),
  .op               (op),
  .literal          (literal),
  .file_addr        (file_addr),
  .dest_sel         (dest_sel),
  .file_rdata       (file_rdata),
  .file_we          (file_we),
  .file_waddr       (file_waddr),
  .work_reg         (work_reg),
  .carry_flag       (carry_flag),
  .digit_carry_flag (digit_carry_flag),
  .zero_flag        (zero_flag),
  .time_out_flag    (time_out_flag),
  .power_down_flag  (power_down_flag),
  .watchdog_counter (watchdog_counter),
  .watchdog_clear   (watchdog_clear),
  .prescaler_clear  (prescaler_clear),
  .osc_stop         (osc_stop),
  .sleeping         (sleeping)
);
`default_nettype wire

// *** sim/testbench.sv ***
/*
  Self-checking bench for alu_exec with a modelled file register array.
  Assumes results appear just after the taking edge and are checked at the next falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import alu_ops_pkg::*;
;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              op_valid = 1'b0;
  logic              dest_sel = 1'b0;
  logic              wake = 1'b0;
  op_e               op = OP_NONE;
  logic [DATA_W-1:0] literal = 8'h00;
  logic [ADDR_W-1:0] file_addr = 7'h00;
  logic [DATA_W-1:0] file_rdata, work_reg, file_wdata, ew;
  logic [WDOG_W-1:0] watchdog_counter;
  logic [ADDR_W-1:0] file_waddr;
  logic              file_we, carry_flag, digit_carry_flag, zero_flag;
  logic              time_out_flag, power_down_flag, watchdog_clear;
  logic              prescaler_clear, osc_stop, sleeping;
  logic              ec, edc, ez, eto, epd, esl;
  logic [DATA_W-1:0] mem [128];
  int                failures = 0;
  int                cmp_count = 0;

  alu_exec i_alu_exec (
    .clock            (clock),
    .rst              (rst),
    .op_valid         (op_valid),
    .op               (op),
    .literal          (literal),
    .file_addr        (file_addr),
    .dest_sel         (dest_sel),
    .file_rdata       (file_rdata),
    .wake             (wake),
    .file_we          (file_we),
    .file_waddr       (file_waddr),
    .file_wdata       (file_wdata),
    .work_reg         (work_reg),
    .carry_flag       (carry_flag),
    .digit_carry_flag (digit_carry_flag),
    .zero_flag        (zero_flag),
    .time_out_flag    (time_out_flag),
    .power_down_flag  (power_down_flag),
    .watchdog_counter (watchdog_counter),
    .watchdog_clear   (watchdog_clear),
    .prescaler_clear  (prescaler_clear),
    .osc_stop         (osc_stop),
    .sleeping         (sleeping)
  );

  always #25 clock = ~clock;
  // The file array answers at once, as the design expects no read wait.
  assign file_rdata = mem[file_addr];
  always @(posedge clock) if (file_we) mem[file_waddr] <= file_wdata;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic exec(input op_e o, input logic [DATA_W-1:0] k,
                      input logic [ADDR_W-1:0] a, input logic d);
    logic [DATA_W-1:0] f, r, s;
    logic              we, sl;
    op_valid <= 1'b1;
    op <= o;
    literal <= k;
    file_addr <= a;
    dest_sel <= d;
    // Expectation is formed mid-cycle so a pending file write has landed.
    @(negedge clock);
    f = mem[a];
    r = ew;
    sl = 1'b0;
    we = 1'b0;
    if (!esl) begin
      case (o)
        OP_SLEEP: begin
          {epd, eto, esl, sl} = 4'h7;
        end
        SUB_FROM_LITERAL_OP, SUB_FROM_FILE_OP: begin
          s = (o == SUB_FROM_FILE_OP) ? f : k;
          r = s - ew;
          ec = s >= ew;
          edc = s[3:0] >= ew[3:0];
          ez = r == 8'h00;
        end
        ROTATE_RIGHT_CARRY_OP: begin
          r = {ec, f[7:1]};
          ec = f[0];
        end
        NIBBLE_SWAP_OP: r = {f[3:0], f[7:4]};
        XOR_LITERAL_OP, XOR_FILE_OP: begin
          r = ew ^ ((o == XOR_FILE_OP) ? f : k);
          ez = r == 8'h00;
        end
        default: ;
      endcase
      we = d && o inside {ROTATE_RIGHT_CARRY_OP, SUB_FROM_FILE_OP,
                          NIBBLE_SWAP_OP, XOR_FILE_OP};
    end
    if (!we) ew = r;
    @(posedge clock);
    op_valid <= 1'b0;
    @(negedge clock);
    chk(work_reg, ew);
    chk({carry_flag, digit_carry_flag, zero_flag, time_out_flag,
         power_down_flag}, {ec, edc, ez, eto, epd});
    chk({sleeping, osc_stop, file_we}, {esl, esl, we});
    if (we) chk({file_waddr, file_wdata}, {a, r});
    chk({watchdog_counter, watchdog_clear, prescaler_clear},
        {WATCHDOG_ZERO, sl, sl});
    @(posedge clock);
  endtask

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    {ew, ec, edc, ez, eto, epd, esl} = {8'h00, 6'h06};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({work_reg, carry_flag, zero_flag, time_out_flag, power_down_flag},
        {8'h00, 4'h3});
    @(posedge clock);
    exec(XOR_LITERAL_OP, 8'h3c, 7'h00, 1'b0);
    exec(SUB_FROM_LITERAL_OP, 8'h3c, 7'h00, 1'b0);
    exec(XOR_LITERAL_OP, 8'h10, 7'h00, 1'b0);
    exec(SUB_FROM_LITERAL_OP, 8'h0f, 7'h00, 1'b0);
    exec(SUB_FROM_LITERAL_OP, 8'h20, 7'h00, 1'b0);
    exec(SUB_FROM_FILE_OP, 8'h00, 7'h7f, 1'b1);
    exec(SUB_FROM_FILE_OP, 8'h00, 7'h05, 1'b0);
    exec(ROTATE_RIGHT_CARRY_OP, 8'h00, 7'h7f, 1'b1);
    exec(ROTATE_RIGHT_CARRY_OP, 8'h00, 7'h7f, 1'b0);
    exec(NIBBLE_SWAP_OP, 8'h00, 7'h03, 1'b0);
    exec(NIBBLE_SWAP_OP, 8'h00, 7'h03, 1'b1);
    exec(XOR_FILE_OP, 8'h00, 7'h03, 1'b1);
    exec(XOR_FILE_OP, 8'h00, 7'h05, 1'b0);
    exec(OP_NONE, 8'h55, 7'h05, 1'b1);
    exec(OP_SLEEP, 8'h00, 7'h00, 1'b0);
    exec(XOR_LITERAL_OP, 8'hff, 7'h00, 1'b0);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    esl = 1'b0;
    @(negedge clock);
    chk(sleeping, esl);
    @(posedge clock);
    exec(XOR_LITERAL_OP, 8'h5a, 7'h00, 1'b0);
    complete_run();
  end

  // Some 20 operations of two cycles each need well under 10 us.
  initial begin
    #50us;
    failures++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
